// ### rtl/bps_block_program.sv
/*
 * Register bank for connection memory block programming and the software
 * resets of the switching datapath and the DPLL.
 * Assumes a synchronous register port with read data one cycle after the
 * read strobe, and a one-cycle frame_pulse at each TDM frame start.
 */
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - A zero-to-one change of the start bit begins the block fill.
// - With fill enable high, the fill completes within two frames.
// - The start bit clears itself when the fill completes.
// - Clearing start or fill enable while start is high aborts the fill.
// - Switch soft reset bit high holds the switching logic in reset.
// - DPLL soft reset bit high holds the DPLL logic in reset.
module bps_block_program #(
    parameter int FRAME_CYCLES = bps_pkg::FRAME_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic frame_pulse,
    output logic [4:0] mode_other,
    output logic switch_soft_reset,
    output logic pll_soft_reset,
    output logic fill_busy,
    output logic cm_wr_en,
    output logic [10:0] cm_addr,
    output logic [2:0] cm_wdata
);
    logic fill_enable_bit_r;
    logic fill_start_r;
    logic [2:0] fill_pattern_field_r;
    logic [4:0] mode_other_r;
    logic [1:0] srst_r;
    logic [15:0] rdata_r;
    logic wr_ctrl;
    logic wr_mode;
    logic wr_srst;
    logic start_rise;
    logic abort;
    logic go;
    logic busy_w;
    logic done_w;
    logic [15:0] rdata_nxt;

    assign wr_ctrl = reg_wr && reg_addr == bps_pkg::CTRL_OFFSET;
    assign wr_mode = reg_wr && reg_addr == bps_pkg::MODE_OFFSET;
    assign wr_srst = reg_wr && reg_addr == bps_pkg::SRST_OFFSET;

    // A write of one over a low start bit is the only way to begin
    assign start_rise = wr_mode && !fill_start_r
        && reg_wdata[bps_pkg::MODE_START_BIT];

    // Either control bit dropping while a fill is requested stops it
    assign abort = fill_start_r && (
        (wr_mode && !reg_wdata[bps_pkg::MODE_START_BIT]) ||
        (wr_ctrl && !reg_wdata[bps_pkg::CTRL_FILL_EN_BIT]));

    // Engine may run only once software has also raised the enable
    assign go = fill_start_r && fill_enable_bit_r && !busy_w
        && !done_w && !abort;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fill_enable_bit_r <= bps_pkg::CTRL_FILL_EN_RST;
        end else if (wr_ctrl) begin
            fill_enable_bit_r <= reg_wdata[bps_pkg::CTRL_FILL_EN_BIT];
        end
    end

    // Completion clears the start bit even against a rewrite of one
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fill_start_r <= 1'b0;
        end else if (done_w || abort) begin
            fill_start_r <= 1'b0;
        end else if (start_rise) begin
            fill_start_r <= 1'b1;
        end
    end

    // Pattern is taken from every write to the mode register, start bit high or low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fill_pattern_field_r <= bps_pkg::MODE_PAT_RST;
            mode_other_r <= bps_pkg::MODE_OTHER_RST;
        end else if (wr_mode) begin
            fill_pattern_field_r <= reg_wdata[bps_pkg::MODE_PAT_LSB +:
                bps_pkg::MODE_PAT_W];
            mode_other_r <= reg_wdata[bps_pkg::MODE_OTHER_LSB +:
                bps_pkg::MODE_OTHER_W];
        end
    end

    // Reserved bits are not stored and read back as zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            srst_r <= bps_pkg::SRST_RST;
        end else if (wr_srst) begin
            srst_r[bps_pkg::SRST_SW_BIT] <=
                reg_wdata[bps_pkg::SRST_SW_BIT];
            srst_r[bps_pkg::SRST_PLL_BIT] <=
                reg_wdata[bps_pkg::SRST_PLL_BIT];
        end
    end

    always_comb begin
        rdata_nxt = '0;
        if (reg_rd) begin
            case (reg_addr)
                bps_pkg::CTRL_OFFSET: begin
                    rdata_nxt[bps_pkg::CTRL_FILL_EN_BIT] = fill_enable_bit_r;
                end
                bps_pkg::MODE_OFFSET: begin
                    rdata_nxt[bps_pkg::MODE_START_BIT] = fill_start_r;
                    rdata_nxt[bps_pkg::MODE_PAT_LSB +: bps_pkg::MODE_PAT_W] =
                        fill_pattern_field_r;
                    rdata_nxt[bps_pkg::MODE_OTHER_LSB +:
                        bps_pkg::MODE_OTHER_W] = mode_other_r;
                end
                bps_pkg::SRST_OFFSET: begin
                    rdata_nxt[bps_pkg::SRST_SW_BIT] =
                        srst_r[bps_pkg::SRST_SW_BIT];
                    rdata_nxt[bps_pkg::SRST_PLL_BIT] =
                        srst_r[bps_pkg::SRST_PLL_BIT];
                end
                default: begin
                    rdata_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign mode_other = mode_other_r;
    assign switch_soft_reset = srst_r[bps_pkg::SRST_SW_BIT];
    assign pll_soft_reset = srst_r[bps_pkg::SRST_PLL_BIT];
    assign fill_busy = busy_w;

    bps_fill_engine u_fill (
        .clk(clk),
        .arst_n(arst_n),
        .go(go),
        .abort(abort),
        .frame_pulse(frame_pulse),
        .pattern(fill_pattern_field_r),
        .busy_r(busy_w),
        .done_r(done_w),
        .cm_wr_r(cm_wr_en),
        .cm_addr_r(cm_addr),
        .cm_data_r(cm_wdata)
    );

    // Helper counters for the checks below
    int unsigned run_cyc_r;
    int unsigned frames_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run_cyc_r <= 0;
            frames_r <= 0;
        end else if (!(fill_start_r && fill_enable_bit_r)) begin
            run_cyc_r <= 0;
            frames_r <= 0;
        end else begin
            run_cyc_r <= run_cyc_r + 1;
            if (frame_pulse) begin
                frames_r <= frames_r + 1;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_fill_begin;
        start_rise && fill_enable_bit_r && !abort;
    endsequence

    sequence s_fill_armed;
        fill_start_r && busy_w;
    endsequence

    a_start_rise_runs: assert property (
        s_fill_begin |=> ##1 s_fill_armed)
        else $error("fill did not start after start bit rose");

    a_fill_two_frames: assert property (
        frames_r <= 2)
        else $error("fill ran past two frame boundaries");

    a_fill_time_bound: assert property (
        run_cyc_r <= 2 * FRAME_CYCLES + 4)
        else $error("fill exceeded two frame periods");

    a_done_clears_start: assert property (
        done_w |=> !fill_start_r && !busy_w)
        else $error("start bit not cleared after fill done");

    a_abort_stops_fill: assert property (
        abort |=> !busy_w && !fill_start_r && !cm_wr_en)
        else $error("abort did not stop the fill");

    a_switch_reset_bit: assert property (
        wr_srst |=> switch_soft_reset ==
            $past(reg_wdata[bps_pkg::SRST_SW_BIT]))
        else $error("switch soft reset not following write");

    a_pll_reset_bit: assert property (
        wr_srst |=> pll_soft_reset == $past(reg_wdata[bps_pkg::SRST_PLL_BIT]))
        else $error("pll soft reset not following write");

    a_fill_write_data: assert property (
        cm_wr_en |-> cm_wdata == fill_pattern_field_r && fill_start_r)
        else $error("fill data differs from pattern field");

    a_fill_address_walk: assert property (
        cm_wr_en && $past(cm_wr_en) |-> cm_addr == $past(cm_addr) + 11'h001)
        else $error("fill address did not step by one");

    a_fill_covers_all: assert property (
        done_w |-> $past(cm_addr) == bps_pkg::CM_LAST)
        else $error("fill ended before last location");

    a_idle_read_zero: assert property (
        !$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");

    a_enable_gates_fill: assert property (
        !fill_enable_bit_r |-> !busy_w)
        else $error("fill engine busy with enable low");

    a_busy_needs_start: assert property (
        busy_w |-> fill_start_r)
        else $error("fill engine busy with start low");

    a_go_raises_busy: assert property (
        go |=> busy_w)
        else $error("fill engine did not start on go");

    a_start_only_by_write: assert property (
        $rose(fill_start_r) |-> $past(wr_mode) &&
            $past(reg_wdata[bps_pkg::MODE_START_BIT]))
        else $error("start bit rose without a host write");

    a_start_clear_cause: assert property (
        $fell(fill_start_r) |-> $past(done_w) || $past(abort))
        else $error("start bit fell without done or abort");

    a_done_one_cycle: assert property (
        done_w |=> !done_w)
        else $error("done pulse longer than one cycle");

    a_start_read_back: assert property (
        reg_rd && reg_addr == bps_pkg::MODE_OFFSET |=>
            reg_rdata[bps_pkg::MODE_START_BIT] == $past(fill_start_r))
        else $error("start bit read back differs");

    a_ctrl_readback: assert property (
        reg_rd && reg_addr == bps_pkg::CTRL_OFFSET |=>
            reg_rdata[bps_pkg::CTRL_FILL_EN_BIT] == $past(fill_enable_bit_r))
        else $error("fill enable read back differs");

    a_srst_readback: assert property (
        reg_rd && reg_addr == bps_pkg::SRST_OFFSET |=>
            reg_rdata[bps_pkg::SRST_SW_BIT] == $past(switch_soft_reset) &&
            reg_rdata[bps_pkg::SRST_PLL_BIT] == $past(pll_soft_reset))
        else $error("soft reset read back differs");

    a_soft_reset_hold: assert property (
        !wr_srst |=> $stable(switch_soft_reset) && $stable(pll_soft_reset))
        else $error("soft reset bits changed without a write");

    a_mode_other_hold: assert property (
        !wr_mode |=> $stable(mode_other))
        else $error("mode bits changed without a write");

    sequence s_sweep_midway;
        cm_wr_en && cm_addr != bps_pkg::CM_LAST && !abort;
    endsequence

    a_sweep_from_zero: assert property (
        $rose(cm_wr_en) |-> cm_addr == '0)
        else $error("sweep did not begin at location zero");

    a_sweep_no_gap: assert property (
        s_sweep_midway |=> cm_wr_en)
        else $error("sweep stopped before the last location");

    a_sweep_stops_last: assert property (
        cm_wr_en && cm_addr == bps_pkg::CM_LAST |=> !cm_wr_en)
        else $error("sweep ran past the last location");

    a_pattern_steady: assert property (
        cm_wr_en && $past(cm_wr_en) |-> $stable(cm_wdata))
        else $error("fill data changed during the sweep");
endmodule // bps_block_program

// ### rtl/bps_fill_engine.sv
/*
 * Fill sequencer: waits for a frame boundary, writes the pattern to every
 * connection memory location, then ends at the next frame boundary.
 * Assumes frame_pulse is one cycle per frame and a frame is longer than
 * the memory depth in clocks.
 */
`timescale 1ns/1ps
module bps_fill_engine (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic go,
    input wire logic abort,
    input wire logic frame_pulse,
    input wire logic [2:0] pattern,
    output logic busy_r,
    output logic done_r,
    output logic cm_wr_r,
    output logic [10:0] cm_addr_r,
    output logic [2:0] cm_data_r
);
    bps_pkg::bps_state_e state_r;
    logic sweep_start;

    // A pulse in the go cycle is taken at once so no frame is lost
    assign sweep_start = frame_pulse && (state_r == bps_pkg::BPS_ARM ||
        (state_r == bps_pkg::BPS_IDLE && go));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= bps_pkg::BPS_IDLE;
        end else if (abort) begin
            state_r <= bps_pkg::BPS_IDLE;
        end else begin
            case (state_r)
                bps_pkg::BPS_IDLE: begin
                    if (sweep_start) begin
                        state_r <= bps_pkg::BPS_FILL;
                    end else if (go) begin
                        state_r <= bps_pkg::BPS_ARM;
                    end
                end
                bps_pkg::BPS_ARM: begin
                    if (frame_pulse) begin
                        state_r <= bps_pkg::BPS_FILL;
                    end
                end
                bps_pkg::BPS_FILL: begin
                    if (cm_wr_r && cm_addr_r == bps_pkg::CM_LAST) begin
                        state_r <= bps_pkg::BPS_HOLD;
                    end
                end
                bps_pkg::BPS_HOLD: begin
                    if (frame_pulse) begin
                        state_r <= bps_pkg::BPS_IDLE;
                    end
                end
                default: begin
                    state_r <= bps_pkg::BPS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            busy_r <= !abort && (state_r != bps_pkg::BPS_IDLE || go);
            done_r <= !abort && state_r == bps_pkg::BPS_HOLD && frame_pulse;
        end
    end

    // Sweep every location once, one write per clock
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cm_wr_r <= 1'b0;
            cm_addr_r <= '0;
            cm_data_r <= bps_pkg::MODE_PAT_RST;
        end else if (abort) begin
            cm_wr_r <= 1'b0;
        end else if (sweep_start) begin
            cm_wr_r <= 1'b1;
            cm_addr_r <= '0;
            cm_data_r <= pattern;
        end else if (cm_wr_r) begin
            cm_wr_r <= cm_addr_r != bps_pkg::CM_LAST;
            // Address rests on the last location once the sweep ends
            if (cm_addr_r != bps_pkg::CM_LAST) begin
                cm_addr_r <= cm_addr_r + 11'h001;
            end
        end
    end
endmodule // bps_fill_engine

// ### rtl/bps_pkg.sv
/*
 * Constants for the block-program and soft-reset register bank:
 * register offsets, field positions, reset values, fill geometry, timing.
 * Assumes a 16-bit register port and a 40 MHz core clock.
 */
package bps_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;

    localparam logic [15:0] CTRL_OFFSET = 16'h0000;
    localparam logic [15:0] MODE_OFFSET = 16'h0001;
    localparam logic [15:0] SRST_OFFSET = 16'h0002;

    // Control register
    localparam int CTRL_FILL_EN_BIT = 0;
    localparam logic CTRL_FILL_EN_RST = 1'b0;

    // Internal mode selection register
    localparam int MODE_START_BIT = 0;
    localparam int MODE_PAT_LSB = 1;
    localparam int MODE_PAT_W = 3;
    localparam int MODE_OTHER_LSB = 4;
    localparam int MODE_OTHER_W = 5;
    localparam logic [2:0] MODE_PAT_RST = 3'h0;
    localparam logic [4:0] MODE_OTHER_RST = 5'h00;

    // Software reset register
    localparam int SRST_PLL_BIT = 0;
    localparam int SRST_SW_BIT = 1;
    localparam logic [1:0] SRST_RST = 2'h0;

    // Connection memory swept by the fill
    localparam int CM_AW = 11;
    localparam logic [10:0] CM_LAST = 11'h7FF;

    // Frame timing
    localparam int CLK_PERIOD_PS = 25000;
    localparam int FRAME_PERIOD_NS = 125000;
    localparam int FRAME_CYCLES =
        (FRAME_PERIOD_NS * 1000) / CLK_PERIOD_PS;

    typedef enum logic [3:0] {
        BPS_IDLE = 4'b0001,
        BPS_ARM = 4'b0010,
        BPS_FILL = 4'b0100,
        BPS_HOLD = 4'b1000
    } bps_state_e;
endpackage

// ### tb/tb_block_program_and_soft_reset.sv
/*
 * Self-checking bench for the block-program and soft-reset register bank.
 * Assumes a register port with one-cycle read latency and a bench-made frame
 * pulse every FR clocks, with FR above the 2048-location sweep.
 */
`timescale 1ns/1ps
module tb_block_program_and_soft_reset;
    localparam int FR = 2100;
    localparam int LIMIT = 20000;
    logic clk, arst_n, reg_wr, reg_rd;
    logic frame_pulse = 1'b0;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, v;
    logic [4:0] mode_other;
    logic switch_soft_reset, pll_soft_reset, fill_busy, cm_wr_en;
    logic [10:0] cm_addr;
    logic [2:0] cm_wdata;
    logic [2:0] exp_pat = 3'h0;
    // Reserved soft reset bits are always written as zero
    logic [15:0] srst_vals [4] =
        '{16'h0001, 16'h0002, 16'h0003, 16'h0000};
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int fcnt = 0;
    int wcount = 0;
    int n;

    bps_block_program #(.FRAME_CYCLES(FR)) dut (
        .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .frame_pulse(frame_pulse),
        .mode_other(mode_other), .switch_soft_reset(switch_soft_reset),
        .pll_soft_reset(pll_soft_reset), .fill_busy(fill_busy),
        .cm_wr_en(cm_wr_en), .cm_addr(cm_addr), .cm_wdata(cm_wdata)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Frame timing source: one-cycle pulse every FR clocks
    always @(posedge clk) begin
        fcnt <= (fcnt == FR - 1) ? 0 : fcnt + 1;
        frame_pulse <= (fcnt == FR - 1);
    end

    task automatic chk(input string nm, input logic [15:0] exp,
                       input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Every memory write must follow the address sweep with the pattern
    always @(negedge clk) begin
        if (cm_wr_en === 1'b1) begin
            chk("cm_addr", {5'h00, wcount[10:0]}, {5'h00, cm_addr});
            chk("cm_wdata", {13'h0000, exp_pat}, {13'h0000, cm_wdata});
            wcount++;
        end
    end

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            num_errors++;
            close_out();
        end
    end

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp,
                      input string nm);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, exp, reg_rdata);
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic done(input string nm);
        $display("Test %s finished, mismatches so far %0d", nm, num_errors);
    endtask

    initial begin
        arst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;

        rd(bps_pkg::CTRL_OFFSET, 16'h0000, "ctrl_reset");
        rd(bps_pkg::MODE_OFFSET, 16'h0000, "mode_reset");
        rd(bps_pkg::SRST_OFFSET, 16'h0000, "srst_reset");
        wr(16'h0003, 16'hFFFF);
        rd(16'h0003, 16'h0000, "unmapped");
        done("reset_values");

        for (int i = 0; i < 4; i++) begin
            v = srst_vals[i];
            wr(bps_pkg::SRST_OFFSET, v);
            #1;
            chk("switch_reset", {15'h0000, v[1]},
                {15'h0000, switch_soft_reset});
            chk("pll_reset", {15'h0000, v[0]},
                {15'h0000, pll_soft_reset});
            rd(bps_pkg::SRST_OFFSET, v & 16'h0003, "srst_read");
        end
        done("soft_reset");

        wr(bps_pkg::CTRL_OFFSET, 16'h0001);
        exp_pat = 3'h3;
        wcount = 0;
        wr(bps_pkg::MODE_OFFSET, 16'h01F7);
        settle(2);
        chk("mode_other", 16'h001F, {11'h000, mode_other});
        chk("busy_start", 16'h0001, {15'h0000, fill_busy});
        n = 2;
        while (fill_busy !== 1'b0 && n < 2 * FR + 100) begin
            settle(1);
            n++;
        end
        chk("fill_in_two_frames", 16'h0001, {15'h0000, n <= 2 * FR});
        chk("cm_write_count", 16'h0800, wcount[15:0]);
        rd(bps_pkg::MODE_OFFSET, 16'h01F6, "start_self_clear");
        done("fill");

        // Start with enable low stays pending until enable is set
        wr(bps_pkg::CTRL_OFFSET, 16'h0000);
        exp_pat = 3'h1;
        wcount = 0;
        wr(bps_pkg::MODE_OFFSET, 16'h0003);
        settle(4);
        chk("busy_gated", 16'h0000, {15'h0000, fill_busy});
        wr(bps_pkg::CTRL_OFFSET, 16'h0001);
        settle(2);
        chk("busy_enabled", 16'h0001, {15'h0000, fill_busy});
        n = 0;
        while (wcount < 100 && n < FR + 200) begin
            settle(1);
            n++;
        end
        // Abort keeps the pattern bits at their current value
        wr(bps_pkg::MODE_OFFSET, 16'h0002);
        settle(1);
        chk("abort_busy", 16'h0000, {15'h0000, fill_busy});
        chk("abort_cm_wr", 16'h0000, {15'h0000, cm_wr_en});
        n = wcount;
        settle(50);
        chk("abort_no_writes", n[15:0], wcount[15:0]);
        done("abort_by_start");

        wr(bps_pkg::MODE_OFFSET, 16'h000B);
        settle(2);
        chk("busy_again", 16'h0001, {15'h0000, fill_busy});
        wr(bps_pkg::CTRL_OFFSET, 16'h0000);
        settle(1);
        chk("abort_by_enable", 16'h0000, {15'h0000, fill_busy});
        rd(bps_pkg::MODE_OFFSET, 16'h000A, "abort_clears_start");
        wr(bps_pkg::CTRL_OFFSET, 16'h0001);
        settle(3);
        chk("no_restart", 16'h0000, {15'h0000, fill_busy});
        done("abort_by_enable");
        close_out();
    end
endmodule // tb_block_program_and_soft_reset
